// file: rtl/ddtc_pkg.sv
package ddtc_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int SAMPLE_W = 16;
   localparam int NUM_CONV = 2;

   // each delay register step is worth 32 DAC clocks
   localparam int DELAY_SHIFT = 5;
   localparam int DELAY_COUNT_W = DATA_W + DELAY_SHIFT;

   localparam logic [ADDR_W-1:0] ADDR_CONV_PAGE = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_UPSAMPLE = 12'h112;
   localparam logic [ADDR_W-1:0] ADDR_GUARD_CFG = 12'h11F;
   localparam logic [ADDR_W-1:0] ADDR_ASSERT_FIRST = 12'h121;
   localparam logic [ADDR_W-1:0] ADDR_ASSERT_SECOND = 12'h122;
   localparam logic [ADDR_W-1:0] ADDR_DEASSERT_FIRST = 12'h123;
   localparam logic [ADDR_W-1:0] ADDR_DEASSERT_SECOND = 12'h124;
   localparam logic [ADDR_W-1:0] ADDR_SETUP_WORD = 12'h12D;
   localparam logic [ADDR_W-1:0] ADDR_TEMP_CTRL = 12'h12F;
   localparam logic [ADDR_W-1:0] ADDR_TEMP_LOW = 12'h132;
   localparam logic [ADDR_W-1:0] ADDR_TEMP_HIGH = 12'h133;
   localparam logic [ADDR_W-1:0] ADDR_TEMP_REFRESH = 12'h134;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET_CTRL = 12'h135;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET_LOW = 12'h136;
   localparam logic [ADDR_W-1:0] ADDR_OFFSET_HIGH = 12'h137;

   localparam logic [1:0] RST_CONV_PAGE = 2'h3;
   localparam logic [2:0] RST_UPSAMPLE = 3'h1;
   localparam logic [7:0] RST_GUARD_CFG = 8'h83;
   localparam logic [7:0] RST_ASSERT_FIRST = 8'h0F;
   localparam logic [7:0] RST_ASSERT_SECOND = 8'h00;
   localparam logic [7:0] RST_DEASSERT_FIRST = 8'hFF;
   localparam logic [7:0] RST_DEASSERT_SECOND = 8'hFF;
   localparam logic [7:0] RST_SETUP_WORD = 8'h46;
   localparam logic [7:0] RST_TEMP_CTRL = 8'h20;

   localparam int AUX_ON_BIT = 0;
   localparam int REFRESH_BIT = 0;
   localparam int OFFSET_ON_BIT = 0;
   localparam logic [7:0] GUARD_CFG_RSVD_MASK = 8'hF7;

   localparam logic [2:0] UPSAMPLE_1X = 3'h0;
   localparam logic [2:0] UPSAMPLE_2X = 3'h1;
   localparam logic [2:0] UPSAMPLE_4X = 3'h3;
   localparam logic [2:0] UPSAMPLE_8X = 3'h4;

   typedef struct packed {
      logic [1:0] fallStages;
      logic [1:0] riseStages;
      logic reserved;
      logic invert;
      logic [1:0] keep;
   } ddtc_guard_cfg_t;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ddtc_reg_req_t;

   typedef enum logic [2:0] {
      GUARD_LOW,
      RISE_FIRST,
      RISE_SECOND,
      GUARD_HIGH,
      FALL_FIRST,
      FALL_SECOND
   } ddtc_guard_state_t;

endpackage

// file: rtl/ddtc_guard_timer.sv
`timescale 1ns/1ps
module ddtc_guard_timer
   import ddtc_pkg::*;
#(
   parameter int COUNT_W = DELAY_COUNT_W
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic load,
   input wire logic [DATA_W-1:0] loadValue,
   output logic expired
);
   logic [COUNT_W-1:0] remaining;
   logic [COUNT_W-1:0] next_remaining;

   always_comb begin
      next_remaining = remaining;
      if (load) begin
         next_remaining = COUNT_W'({loadValue, {DELAY_SHIFT{1'b0}}});
      end else if (remaining != '0) begin
         next_remaining = remaining - COUNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         remaining <= '0;
      end else begin
         remaining <= next_remaining;
      end
   end

   assign expired = (remaining == '0);
endmodule

// file: rtl/ddtc_datapath_regs.sv
`timescale 1ns/1ps
module ddtc_datapath_regs (
   input wire logic clk,
   input wire logic nrst,
   input ddtc_pkg::ddtc_reg_req_t regReq,
   output logic [ddtc_pkg::DATA_W-1:0] regRdata,
   input wire logic transmitGateInput,
   output logic guardOutputPin,
   output logic [2:0] upsampleFactorSelect,
   output logic [ddtc_pkg::DATA_W-1:0] datapathSetup,
   output logic auxConverterOn,
   input wire logic [ddtc_pkg::SAMPLE_W-1:0] tempSample,
   input wire logic [ddtc_pkg::SAMPLE_W-1:0] sampleIn [ddtc_pkg::NUM_CONV],
   output logic [ddtc_pkg::SAMPLE_W-1:0] sampleOut [ddtc_pkg::NUM_CONV]
);
   import ddtc_pkg::*;

   // saturating add keeps a large offset from wrapping the waveform
   function automatic logic [SAMPLE_W-1:0] satAdd(input logic [SAMPLE_W-1:0] a,
                                                   input logic [SAMPLE_W-1:0] b);
      logic [SAMPLE_W:0] s;
      s = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
      if (s[SAMPLE_W] != s[SAMPLE_W-1]) begin
         satAdd = s[SAMPLE_W] ? 16'h8000 : 16'h7FFF;
      end else begin
         satAdd = s[SAMPLE_W-1:0];
      end
   endfunction

   function automatic logic isValidState(input ddtc_guard_state_t s);
      isValidState = (s == GUARD_HIGH) || (s == FALL_FIRST) || (s == FALL_SECOND);
   endfunction

   logic [1:0] convPage, next_convPage;
   logic [2:0] next_upsample;
   ddtc_guard_cfg_t guardCfg, next_guardCfg;
   logic [7:0] assertFirst, next_assertFirst;
   logic [7:0] assertSecond, next_assertSecond;
   logic [7:0] deassertFirst, next_deassertFirst;
   logic [7:0] deassertSecond, next_deassertSecond;
   logic [7:0] next_setup;
   logic [7:0] tempCtrl, next_tempCtrl;
   logic refreshBit, next_refreshBit;
   logic offsetAdderOn, next_offsetAdderOn;
   logic [SAMPLE_W-1:0] offsetValue [NUM_CONV];
   logic [SAMPLE_W-1:0] next_offsetValue [NUM_CONV];
   logic [SAMPLE_W-1:0] tempCode, next_tempCode;
   logic [7:0] next_rdata;
   logic wrHit;
   logic [SAMPLE_W-1:0] pageOffset;

   assign wrHit = regReq.write;
   assign pageOffset = convPage[0] ? offsetValue[0] : offsetValue[1];

   // register file and temperature capture
   always_comb begin
      next_convPage = convPage;
      next_upsample = upsampleFactorSelect;
      next_guardCfg = guardCfg;
      next_assertFirst = assertFirst;
      next_assertSecond = assertSecond;
      next_deassertFirst = deassertFirst;
      next_deassertSecond = deassertSecond;
      next_setup = datapathSetup;
      next_tempCtrl = tempCtrl;
      next_refreshBit = refreshBit;
      next_offsetAdderOn = offsetAdderOn;
      next_offsetValue = offsetValue;
      next_tempCode = tempCode;
      if (wrHit) begin
         case (regReq.addr)
            ADDR_CONV_PAGE: next_convPage = regReq.wdata[1:0];
            ADDR_UPSAMPLE: next_upsample = regReq.wdata[2:0];
            ADDR_GUARD_CFG: next_guardCfg = regReq.wdata & GUARD_CFG_RSVD_MASK;
            ADDR_ASSERT_FIRST: next_assertFirst = regReq.wdata;
            ADDR_ASSERT_SECOND: next_assertSecond = regReq.wdata;
            ADDR_DEASSERT_FIRST: next_deassertFirst = regReq.wdata;
            ADDR_DEASSERT_SECOND: next_deassertSecond = regReq.wdata;
            ADDR_SETUP_WORD: next_setup = regReq.wdata;
            ADDR_TEMP_CTRL: next_tempCtrl = regReq.wdata;
            ADDR_TEMP_REFRESH: next_refreshBit = regReq.wdata[REFRESH_BIT];
            ADDR_OFFSET_CTRL: next_offsetAdderOn = regReq.wdata[OFFSET_ON_BIT];
            ADDR_OFFSET_LOW: begin
               for (int i = 0; i < NUM_CONV; i++) begin
                  if (convPage[i]) begin
                     next_offsetValue[i][7:0] = regReq.wdata;
                  end
               end
            end
            ADDR_OFFSET_HIGH: begin
               for (int i = 0; i < NUM_CONV; i++) begin
                  if (convPage[i]) begin
                     next_offsetValue[i][15:8] = regReq.wdata;
                  end
               end
            end
            default: ;
         endcase
      end
      // a code is taken only while the aux converter is powered
      if (next_refreshBit && !refreshBit && tempCtrl[AUX_ON_BIT]) begin
         next_tempCode = tempSample;
      end
   end

   // read data lags the address by one clock
   always_comb begin
      case (regReq.addr)
         ADDR_CONV_PAGE: next_rdata = {6'h00, convPage};
         ADDR_UPSAMPLE: next_rdata = {5'h00, upsampleFactorSelect};
         ADDR_GUARD_CFG: next_rdata = guardCfg;
         ADDR_ASSERT_FIRST: next_rdata = assertFirst;
         ADDR_ASSERT_SECOND: next_rdata = assertSecond;
         ADDR_DEASSERT_FIRST: next_rdata = deassertFirst;
         ADDR_DEASSERT_SECOND: next_rdata = deassertSecond;
         ADDR_SETUP_WORD: next_rdata = datapathSetup;
         ADDR_TEMP_CTRL: next_rdata = tempCtrl;
         ADDR_TEMP_LOW: next_rdata = tempCode[7:0];
         ADDR_TEMP_HIGH: next_rdata = tempCode[15:8];
         ADDR_TEMP_REFRESH: next_rdata = {7'h00, refreshBit};
         ADDR_OFFSET_CTRL: next_rdata = {7'h00, offsetAdderOn};
         ADDR_OFFSET_LOW: next_rdata = pageOffset[7:0];
         ADDR_OFFSET_HIGH: next_rdata = pageOffset[15:8];
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         convPage <= RST_CONV_PAGE;
         upsampleFactorSelect <= RST_UPSAMPLE;
         guardCfg <= RST_GUARD_CFG;
         assertFirst <= RST_ASSERT_FIRST;
         assertSecond <= RST_ASSERT_SECOND;
         deassertFirst <= RST_DEASSERT_FIRST;
         deassertSecond <= RST_DEASSERT_SECOND;
         datapathSetup <= RST_SETUP_WORD;
         tempCtrl <= RST_TEMP_CTRL;
         refreshBit <= 1'b0;
         offsetAdderOn <= 1'b0;
         offsetValue <= '{default: '0};
         tempCode <= '0;
         regRdata <= '0;
         auxConverterOn <= 1'b0;
      end else begin
         convPage <= next_convPage;
         upsampleFactorSelect <= next_upsample;
         guardCfg <= next_guardCfg;
         assertFirst <= next_assertFirst;
         assertSecond <= next_assertSecond;
         deassertFirst <= next_deassertFirst;
         deassertSecond <= next_deassertSecond;
         datapathSetup <= next_setup;
         tempCtrl <= next_tempCtrl;
         refreshBit <= next_refreshBit;
         offsetAdderOn <= next_offsetAdderOn;
         offsetValue <= next_offsetValue;
         tempCode <= next_tempCode;
         regRdata <= next_rdata;
         auxConverterOn <= next_tempCtrl[AUX_ON_BIT];
      end
   end

   // offset adder, one register stage
   logic [SAMPLE_W-1:0] next_sampleOut [NUM_CONV];
   always_comb begin
      for (int i = 0; i < NUM_CONV; i++) begin
         next_sampleOut[i] = offsetAdderOn ? satAdd(sampleIn[i], offsetValue[i])
                                           : sampleIn[i];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sampleOut <= '{default: '0};
      end else begin
         sampleOut <= next_sampleOut;
      end
   end

   // transmit gate pin synchroniser and edge detect
   logic gateMeta, gateLevel, gateLast;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         gateMeta <= 1'b0;
         gateLevel <= 1'b0;
         gateLast <= 1'b0;
      end else begin
         gateMeta <= transmitGateInput;
         gateLevel <= gateMeta;
         gateLast <= gateLevel;
      end
   end

   logic gateRise, gateFall;
   assign gateRise = gateLevel && !gateLast;
   assign gateFall = !gateLevel && gateLast;

   // guard sequencer; one timer is reloaded for each stage
   ddtc_guard_state_t state, next_state;
   logic timerLoad;
   logic [7:0] timerValue;
   logic timerExpired;
   logic next_guard;

   ddtc_guard_timer #(.COUNT_W(DELAY_COUNT_W)) u_timer (
      .clk(clk),
      .nrst(nrst),
      .load(timerLoad),
      .loadValue(timerValue),
      .expired(timerExpired)
   );

   always_comb begin
      next_state = state;
      timerLoad = 1'b0;
      timerValue = assertFirst;
      case (state)
         GUARD_LOW: begin
            if (gateRise) begin
               if (guardCfg.riseStages == 2'h0) begin
                  next_state = GUARD_HIGH;
               end else begin
                  timerLoad = 1'b1;
                  timerValue = assertFirst;
                  next_state = RISE_FIRST;
               end
            end
         end
         RISE_FIRST: begin
            // gate dropped before the guard rose: stay invalid
            if (!gateLevel) begin
               next_state = GUARD_LOW;
            end else if (timerExpired) begin
               if (guardCfg.riseStages >= 2'h2) begin
                  timerLoad = 1'b1;
                  timerValue = assertSecond;
                  next_state = RISE_SECOND;
               end else begin
                  next_state = GUARD_HIGH;
               end
            end
         end
         RISE_SECOND: begin
            if (!gateLevel) begin
               next_state = GUARD_LOW;
            end else if (timerExpired) begin
               next_state = GUARD_HIGH;
            end
         end
         GUARD_HIGH: begin
            if (gateFall) begin
               if (guardCfg.fallStages == 2'h0) begin
                  next_state = GUARD_LOW;
               end else begin
                  timerLoad = 1'b1;
                  timerValue = deassertFirst;
                  next_state = FALL_FIRST;
               end
            end
         end
         FALL_FIRST: begin
            if (gateLevel) begin
               next_state = GUARD_HIGH;
            end else if (timerExpired) begin
               if (guardCfg.fallStages >= 2'h2) begin
                  timerLoad = 1'b1;
                  timerValue = deassertSecond;
                  next_state = FALL_SECOND;
               end else begin
                  next_state = GUARD_LOW;
               end
            end
         end
         FALL_SECOND: begin
            if (gateLevel) begin
               next_state = GUARD_HIGH;
            end else if (timerExpired) begin
               next_state = GUARD_LOW;
            end
         end
         default: next_state = GUARD_LOW;
      endcase
      next_guard = isValidState(next_state) ^ guardCfg.invert;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         state <= GUARD_LOW;
         guardOutputPin <= 1'b0;
      end else begin
         state <= next_state;
         guardOutputPin <= next_guard;
      end
   end

   // helper: cycles spent in the current state and the count loaded
   logic [DELAY_COUNT_W-1:0] stateAge;
   logic [DELAY_COUNT_W-1:0] loadedCount;
   always_ff @(posedge clk) begin
      if (!nrst) begin
         stateAge <= '0;
         loadedCount <= '0;
      end else begin
         stateAge <= (next_state != state) ? '0 : stateAge + DELAY_COUNT_W'(1);
         if (timerLoad) begin
            loadedCount <= DELAY_COUNT_W'({timerValue, {DELAY_SHIFT{1'b0}}});
         end
      end
   end

   chk_guard_polarity: assert property (@(posedge clk) disable iff (!nrst)
      guardOutputPin == (isValidState(state) ^ $past(guardCfg.invert)))
      else $error("guard pin polarity wrong");

   chk_assert_first_delay: assert property (@(posedge clk) disable iff (!nrst)
      (state == RISE_FIRST && next_state != RISE_FIRST && gateLevel)
      |-> stateAge == loadedCount && loadedCount[4:0] == 5'h00)
      else $error("first assert delay length wrong");

   chk_assert_second_delay: assert property (@(posedge clk) disable iff (!nrst)
      (state == RISE_SECOND && next_state == GUARD_HIGH) |-> stateAge == loadedCount)
      else $error("second assert delay length wrong");

   chk_deassert_first_delay: assert property (@(posedge clk) disable iff (!nrst)
      (state == FALL_FIRST && next_state != FALL_FIRST && !gateLevel)
      |-> stateAge == loadedCount)
      else $error("first deassert delay length wrong");

   chk_deassert_second_delay: assert property (@(posedge clk) disable iff (!nrst)
      (state == FALL_SECOND && next_state == GUARD_LOW) |-> stateAge == loadedCount)
      else $error("second deassert delay length wrong");

   chk_stage_chain: assert property (@(posedge clk) disable iff (!nrst)
      (state == RISE_FIRST && timerExpired && gateLevel)
      |=> state == (($past(guardCfg.riseStages) >= 2'h2) ? RISE_SECOND : GUARD_HIGH))
      else $error("rise stages not chained as selected");

   chk_no_rise_stages: assert property (@(posedge clk) disable iff (!nrst)
      (state == GUARD_LOW && gateRise && guardCfg.riseStages == 2'h0)
      |=> state == GUARD_HIGH ##1 guardOutputPin == !$past(guardCfg.invert))
      else $error("zero rise stages did not raise guard at once");

   chk_upsample_write: assert property (@(posedge clk) disable iff (!nrst)
      (regReq.write && regReq.addr == ADDR_UPSAMPLE)
      |=> upsampleFactorSelect == $past(regReq.wdata[2:0]))
      else $error("upsample factor not updated");

   chk_aux_enable: assert property (@(posedge clk) disable iff (!nrst)
      (regReq.write && regReq.addr == ADDR_TEMP_CTRL)
      |=> auxConverterOn == $past(regReq.wdata[AUX_ON_BIT]))
      else $error("aux converter enable not followed");

   chk_temp_capture: assert property (@(posedge clk) disable iff (!nrst)
      (next_refreshBit && !refreshBit && auxConverterOn)
      |=> tempCode == $past(tempSample) ##2 $past(regReq.addr) != ADDR_TEMP_LOW
          || regRdata == $past(tempCode[7:0]))
      else $error("temperature code not captured on refresh edge");

   chk_offset_bypass: assert property (@(posedge clk) disable iff (!nrst)
      !offsetAdderOn |=> sampleOut[0] == $past(sampleIn[0]) && sampleOut[1] == $past(sampleIn[1]))
      else $error("offset applied while adder is off");

   chk_offset_sum: assert property (@(posedge clk) disable iff (!nrst)
      offsetAdderOn |=> sampleOut[1] == satAdd($past(sampleIn[1]), $past(offsetValue[1])))
      else $error("offset sum wrong");

   chk_offset_page: assert property (@(posedge clk) disable iff (!nrst)
      (regReq.write && regReq.addr == ADDR_OFFSET_LOW && !convPage[1])
      |=> $stable(offsetValue[1]))
      else $error("offset written to unselected converter");

endmodule

// file: verif/ddtc_rf_stage.sv
`timescale 1ns/1ps
module ddtc_rf_stage (
   input wire logic clk,
   input wire logic gateLevel,
   input wire logic invertSel,
   input wire logic guardOutputPin,
   output logic transmitGateInput,
   output logic rfActive,
   output int delayCycles
);
   logic lastGate;
   initial begin
      transmitGateInput = 1'b0;
      lastGate = 1'b0;
      delayCycles = 0;
   end
   // the enable source moves only between rising edges, as a real driver would
   always @(negedge clk) begin
      transmitGateInput <= gateLevel;
   end
   // downstream stage reads the pin through the polarity it was built for
   assign rfActive = guardOutputPin ^ invertSel;
   // edges from an enable change until the stage follows it
   always @(posedge clk) begin
      if (transmitGateInput != lastGate) begin
         delayCycles <= 1;
      end else if (rfActive != transmitGateInput) begin
         delayCycles <= delayCycles + 1;
      end
      lastGate <= transmitGateInput;
   end
endmodule

// file: verif/ddtc_datapath_regs_test.sv
`timescale 1ns/1ps
module ddtc_datapath_regs_test;
   import ddtc_pkg::*;
   logic clk, nrst, gateLevel, invSel, transmitGateInput, guardOutputPin, rfActive, auxConverterOn;
   ddtc_reg_req_t req;
   logic [7:0] regRdata, datapathSetup;
   logic [2:0] upsampleFactorSelect;
   logic [15:0] tempSample;
   logic [15:0] sIn [2];
   logic [15:0] sOut [2];
   int delayCycles;
   int failCount = 0;
   int checks = 0;

   ddtc_datapath_regs u_dut (.clk(clk), .nrst(nrst), .regReq(req), .regRdata(regRdata),
      .transmitGateInput(transmitGateInput), .guardOutputPin(guardOutputPin),
      .upsampleFactorSelect(upsampleFactorSelect), .datapathSetup(datapathSetup),
      .auxConverterOn(auxConverterOn), .tempSample(tempSample), .sampleIn(sIn),
      .sampleOut(sOut));
   ddtc_rf_stage u_rf (.clk(clk), .gateLevel(gateLevel), .invertSel(invSel),
      .guardOutputPin(guardOutputPin), .transmitGateInput(transmitGateInput),
      .rfActive(rfActive), .delayCycles(delayCycles));

   always #2.5 clk = ~clk;

   task automatic endSim;
      $display("checks %0d mismatches %0d", checks, failCount);
      if (failCount == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failCount++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one idle cycle after each write keeps the strobe a clean pulse
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      req.write = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge clk);
      req.write = 1'b0;
      @(negedge clk);
   endtask

   task automatic rdChk(input logic [11:0] a, input logic [7:0] exp);
      req.addr = a;
      @(negedge clk);
      chk({8'h00, regRdata}, {8'h00, exp});
   endtask

   task automatic edgeDelay(input logic lvl, output int d);
      int n;
      gateLevel = lvl;
      n = 0;
      while (!(rfActive === lvl && transmitGateInput === lvl) && n < 20000) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20000) begin
         failCount++;
         $display("mismatch at %0t: guard wait ran out", $time);
         endSim();
      end else begin
         d = delayCycles;
      end
   endtask

   logic [11:0] ra [15] = '{12'h112, 12'h11F, 12'h121, 12'h122, 12'h123, 12'h124, 12'h12D,
      12'h12F, 12'h132, 12'h133, 12'h134, 12'h135, 12'h136, 12'h137, 12'h200};
   logic [7:0] rv [15] = '{8'h01, 8'h83, 8'h0F, 8'h00, 8'hFF, 8'hFF, 8'h46, 8'h20, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h3, 3'h4};

   task automatic test_reset_values;
      chk({13'h0000, upsampleFactorSelect}, 16'h0001);
      chk({8'h00, datapathSetup}, 16'h0046);
      chk({15'h0000, auxConverterOn}, 16'h0000);
      wr(12'h132, 8'h55);
      wr(12'h200, 8'h55);
      for (int i = 0; i < 15; i++) begin
         rdChk(ra[i], rv[i]);
      end
      $display("test reset values done");
   endtask

   task automatic test_upsample_setup;
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_UPSAMPLE, {5'h00, codes[i]});
         chk({13'h0000, upsampleFactorSelect}, {13'h0000, codes[i]});
         rdChk(ADDR_UPSAMPLE, {5'h00, codes[i]});
      end
      wr(ADDR_SETUP_WORD, 8'h8B);
      chk({8'h00, datapathSetup}, 16'h008B);
      $display("test upsample and setup done");
   endtask

   task automatic test_temperature;
      tempSample = 16'hA5C3;
      wr(ADDR_TEMP_CTRL, 8'h21);
      chk({15'h0000, auxConverterOn}, 16'h0001);
      wr(ADDR_TEMP_REFRESH, 8'h01);
      rdChk(ADDR_TEMP_LOW, 8'hC3);
      rdChk(ADDR_TEMP_HIGH, 8'hA5);
      tempSample = 16'h1111;
      wr(ADDR_TEMP_REFRESH, 8'h01);
      rdChk(ADDR_TEMP_LOW, 8'hC3);
      wr(ADDR_TEMP_REFRESH, 8'h00);
      wr(ADDR_TEMP_REFRESH, 8'h01);
      rdChk(ADDR_TEMP_HIGH, 8'h11);
      wr(ADDR_TEMP_CTRL, 8'h20);
      chk({15'h0000, auxConverterOn}, 16'h0000);
      $display("test temperature done");
   endtask

   task automatic test_offset;
      sIn[0] = 16'h1234;
      sIn[1] = 16'h1234;
      wr(ADDR_CONV_PAGE, 8'h01);
      wr(ADDR_OFFSET_LOW, 8'h00);
      wr(ADDR_OFFSET_HIGH, 8'h01);
      chk(sOut[0], 16'h1234);
      wr(ADDR_OFFSET_CTRL, 8'h01);
      chk(sOut[0], 16'h1334);
      chk(sOut[1], 16'h1234);
      wr(ADDR_CONV_PAGE, 8'h02);
      wr(ADDR_OFFSET_LOW, 8'hF0);
      wr(ADDR_OFFSET_HIGH, 8'hFF);
      chk(sOut[1], 16'h1224);
      chk(sOut[0], 16'h1334);
      wr(ADDR_OFFSET_CTRL, 8'h00);
      chk(sOut[1], 16'h1234);
      $display("test offset done");
   endtask

   task automatic test_guard_delays;
      int a, b, c, e, f, g, h, k;
      wr(ADDR_DEASSERT_FIRST, 8'h12);
      wr(ADDR_ASSERT_FIRST, 8'h01);
      wr(ADDR_GUARD_CFG, 8'h53);
      edgeDelay(1'b1, a);
      edgeDelay(1'b0, e);
      wr(ADDR_ASSERT_FIRST, 8'h03);
      wr(ADDR_DEASSERT_FIRST, 8'h14);
      edgeDelay(1'b1, b);
      edgeDelay(1'b0, f);
      chk(16'(b - a), 16'h0040);
      chk(16'(f - e), 16'h0040);
      wr(ADDR_GUARD_CFG, 8'hA3);
      wr(ADDR_ASSERT_SECOND, 8'h01);
      wr(ADDR_DEASSERT_SECOND, 8'h01);
      edgeDelay(1'b1, c);
      edgeDelay(1'b0, g);
      chk(16'(c - b), 16'h0021);
      chk(16'(g - f), 16'h0021);
      wr(ADDR_ASSERT_SECOND, 8'h03);
      wr(ADDR_DEASSERT_SECOND, 8'h03);
      edgeDelay(1'b1, h);
      edgeDelay(1'b0, k);
      chk(16'(h - c), 16'h0040);
      chk(16'(k - g), 16'h0040);
      $display("test guard delays done");
   endtask

   task automatic test_invert_abort;
      int m;
      logic seen;
      wr(ADDR_GUARD_CFG, 8'h57);
      invSel = 1'b1;
      chk({15'h0000, guardOutputPin}, 16'h0001);
      edgeDelay(1'b1, m);
      chk({15'h0000, guardOutputPin}, 16'h0000);
      edgeDelay(1'b0, m);
      wr(ADDR_GUARD_CFG, 8'h53);
      invSel = 1'b0;
      // enable drops about 40 cycles into the 96-cycle rise hold-off, so the pin must stay low
      gateLevel = 1'b1;
      seen = 1'b0;
      repeat (40) begin
         @(negedge clk);
         seen = seen | guardOutputPin;
      end
      gateLevel = 1'b0;
      repeat (200) begin
         @(negedge clk);
         seen = seen | guardOutputPin;
      end
      chk({15'h0000, seen}, 16'h0000);
      // no rise stages: guard follows the synchronised edge at once
      wr(ADDR_GUARD_CFG, 8'h43);
      edgeDelay(1'b1, m);
      chk(16'(m), 16'h0003);
      edgeDelay(1'b0, m);
      chk(16'(m), 16'h0284);
      $display("test invert and abort done");
   endtask

   initial begin
      clk = 1'b0;
      nrst = 1'b0;
      req = '0;
      gateLevel = 1'b0;
      invSel = 1'b0;
      tempSample = 16'h0000;
      sIn[0] = 16'h0000;
      sIn[1] = 16'h0000;
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      test_reset_values();
      test_upsample_setup();
      test_temperature();
      test_offset();
      test_guard_delays();
      test_invert_abort();
      endSim();
   end
endmodule
